// ==== logic/bus_glue_defs.svh ====
`ifndef BUS_GLUE_DEFS_SVH
`define BUS_GLUE_DEFS_SVH

// ************************************************************
// Timing and field constants
// ************************************************************
`define CLOCK_HZ          50000000
`define XTAL_HZ           4915200
// Missing acknowledge timeout in ns, and derived cycles
`define FAULT_TIMEOUT_NS  10000
`define FAULT_CYCLES      ((`FAULT_TIMEOUT_NS * (`CLOCK_HZ / 1000000)) / 1000)
`define FAULT_CNT_W       10
// Peripheral enable: one enable cycle is ten processor clocks
`define ENABLE_LOW_CLKS   6
`define ENABLE_HIGH_CLKS  4
`define ENABLE_CNT_W      4
`define WORD_ADDR_W       23
`define BYTE_ADDR_W       24
`define IRQ_LEVELS        8
`define ABORT_LEVEL       3'h7
`define BAUD_SEL_W        3
`define BAUD_DIV_BASE     16

`endif

// ==== logic/bus_glue_pkg.sv ====
package bus_glue_pkg;
  // Peripheral cycle states
  typedef enum logic [1:0] {
    PERIPH_IDLE = 2'b00,
    PERIPH_SYNC = 2'b01,
    PERIPH_XFER = 2'b10,
    PERIPH_DONE = 2'b11
  } periph_state_t;
endpackage : bus_glue_pkg

// ==== logic/cpu_bus_glue_logic.sv ====
`timescale 1ns/1ps
`include "bus_glue_defs.svh"
module cpu_bus_glue_logic (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Processor bus (asynchronous)
  input  wire logic                     address_strobe_line_n,
  input  wire logic                     read_write,
  input  wire logic                     byte_select_bit,
  input  wire logic [`WORD_ADDR_W-1:0]  word_addr,
  input  wire logic [15:0]              cpu_wdata,
  input  wire logic                     periph_select,
  input  wire logic                     mem_ack,
  // Jumpers
  input  wire logic                     fault_jumper,
  input  wire logic [`BAUD_SEL_W-1:0]   baud_select,
  // Interrupt sources, bit 7 is the abort key
  input  wire logic [`IRQ_LEVELS-1:0]   irq_request,
  // Fixed serial crystal sampled as ordinary input
  input  wire logic                     xtal_clock,
  // Byte lane read data from memories and adapters
  input  wire logic [7:0]               lane_rdata,
  // Outputs to processor
  output logic [15:0]                   cpu_rdata,
  output logic                          upper_byte_strobe_n,
  output logic                          lower_byte_strobe_n,
  output logic                          transfer_acknowledge_n,
  output logic                          bus_fault_n,
  output logic [2:0]                    irq_level_n,
  output logic                          valid_peripheral_address_n,
  output logic                          periph_enable,
  // Memory side
  output logic [`BYTE_ADDR_W-1:0]       byte_addr,
  output logic                          upper_write_n,
  output logic                          lower_write_n,
  output logic                          mem_read_n,
  output logic [7:0]                    lane_wdata,
  // Serial adapter baud clock
  output logic                          baud_clock
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Three-stage; a change counts when stages two and three agree
  logic [2:0] as_sync, xt_sync;
  logic       as_act, next_as_act, xt_lvl, next_xt_lvl;
  always_comb begin
    next_as_act = as_act;
    next_xt_lvl = xt_lvl;
    if (as_sync[1] == as_sync[2]) next_as_act = ~as_sync[2];
    if (xt_sync[1] == xt_sync[2]) next_xt_lvl = xt_sync[2];
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      as_sync <= 3'h7;
      xt_sync <= 3'h0;
      as_act  <= 1'b0;
      xt_lvl  <= 1'b0;
    end else begin
      as_sync <= {as_sync[1:0], address_strobe_line_n};
      xt_sync <= {xt_sync[1:0], xtal_clock};
      as_act  <= next_as_act;
      xt_lvl  <= next_xt_lvl;
    end
  end

  // ************************************************************
  // Byte strobes, lanes and address
  // ************************************************************
  // Bus inputs are stable while the strobe is held, so they are
  // registered directly once the synchronised strobe is seen.
  logic [15:0]             next_rdata;
  logic                    next_uds, next_lds, next_uw, next_lw, next_rd;
  logic [7:0]              next_wdata;
  logic [`BYTE_ADDR_W-1:0] next_addr;
  logic                    mem_cycle;
  assign mem_cycle = as_act & ~periph_select;
  always_comb begin
    next_uds   = ~(as_act & ~byte_select_bit);
    next_lds   = ~(as_act & byte_select_bit);
    next_addr  = {word_addr, byte_select_bit};
    next_uw    = ~(mem_cycle & ~read_write & ~byte_select_bit);
    next_lw    = ~(mem_cycle & ~read_write & byte_select_bit);
    next_rd    = ~(mem_cycle & read_write);
    next_wdata = byte_select_bit ? cpu_wdata[7:0] : cpu_wdata[15:8];
    // Reads steer to one lane; writes mirror the byte on both lanes
    if (read_write)
      next_rdata = byte_select_bit ? {8'h00, lane_rdata} : {lane_rdata, 8'h00};
    else
      next_rdata = {lane_rdata, lane_rdata};
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      byte_addr           <= '0;
      upper_write_n       <= 1'b1;
      lower_write_n       <= 1'b1;
      mem_read_n          <= 1'b1;
      lane_wdata          <= 8'h00;
      cpu_rdata           <= 16'h0000;
    end else begin
      upper_byte_strobe_n <= next_uds;
      lower_byte_strobe_n <= next_lds;
      byte_addr           <= next_addr;
      upper_write_n       <= next_uw;
      lower_write_n       <= next_lw;
      mem_read_n          <= next_rd;
      lane_wdata          <= next_wdata;
      cpu_rdata           <= next_rdata;
    end
  end

  // ************************************************************
  // Peripheral cycle: valid address and enable, no acknowledge
  // ************************************************************
  bus_glue_pkg::periph_state_t       pstate, next_pstate;
  logic [`ENABLE_CNT_W-1:0]          ecnt, next_ecnt;
  logic                              next_vma, next_en;
  logic                              ephase, next_ephase;
  always_comb begin
    next_pstate = pstate;
    next_ecnt   = ecnt + 1'b1;
    next_ephase = ephase;
    // Free-running enable clock, low then high phase
    if (!ephase && ecnt == `ENABLE_CNT_W'(`ENABLE_LOW_CLKS - 1)) begin
      next_ephase = 1'b1;
      next_ecnt   = '0;
    end else if (ephase && ecnt == `ENABLE_CNT_W'(`ENABLE_HIGH_CLKS - 1)) begin
      next_ephase = 1'b0;
      next_ecnt   = '0;
    end
    case (pstate)
      bus_glue_pkg::PERIPH_IDLE: begin
        if (as_act && periph_select) next_pstate = bus_glue_pkg::PERIPH_SYNC;
      end
      // Wait for a low phase so the whole enable pulse is used
      bus_glue_pkg::PERIPH_SYNC: begin
        if (!as_act) next_pstate = bus_glue_pkg::PERIPH_IDLE;
        else if (!ephase) next_pstate = bus_glue_pkg::PERIPH_XFER;
      end
      bus_glue_pkg::PERIPH_XFER: begin
        if (!as_act) next_pstate = bus_glue_pkg::PERIPH_IDLE;
        else if (ephase && next_ephase == 1'b0) next_pstate = bus_glue_pkg::PERIPH_DONE;
      end
      bus_glue_pkg::PERIPH_DONE: begin
        if (!as_act) next_pstate = bus_glue_pkg::PERIPH_IDLE;
      end
      default: next_pstate = bus_glue_pkg::PERIPH_IDLE;
    endcase
    next_vma = ~(pstate == bus_glue_pkg::PERIPH_XFER);
    next_en  = next_ephase;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pstate                     <= bus_glue_pkg::PERIPH_IDLE;
      ecnt                       <= '0;
      ephase                     <= 1'b0;
      valid_peripheral_address_n <= 1'b1;
      periph_enable              <= 1'b0;
    end else begin
      pstate                     <= next_pstate;
      ecnt                       <= next_ecnt;
      ephase                     <= next_ephase;
      valid_peripheral_address_n <= next_vma;
      periph_enable              <= next_en;
    end
  end

  // ************************************************************
  // Acknowledge and missing-acknowledge fault latch
  // ************************************************************
  // Adapter cycles end on enable timing; the processor must not see an
  // acknowledge for them, only the memory cycle does.
  logic [`FAULT_CNT_W-1:0] fcnt, next_fcnt;
  logic                    next_ack, next_fault, fault, acked, next_acked;
  always_comb begin
    next_acked = acked;
    next_fcnt  = fcnt;
    next_fault = fault;
    next_ack   = ~(mem_cycle & mem_ack);
    if (!as_act) begin
      next_fcnt  = '0;
      next_fault = 1'b0;
      next_acked = 1'b0;
    end else begin
      if (mem_cycle && mem_ack) next_acked = 1'b1;
      if (!acked && !(mem_cycle && mem_ack) && !fault) begin
        if (fcnt == `FAULT_CNT_W'(`FAULT_CYCLES - 1))
          next_fault = fault_jumper;
        else
          next_fcnt = fcnt + 1'b1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      fcnt                   <= '0;
      fault                  <= 1'b0;
      acked                  <= 1'b0;
      transfer_acknowledge_n <= 1'b1;
      bus_fault_n            <= 1'b1;
    end else begin
      fcnt                   <= next_fcnt;
      fault                  <= next_fault;
      acked                  <= next_acked;
      transfer_acknowledge_n <= next_ack;
      bus_fault_n            <= ~next_fault;
    end
  end

  // ************************************************************
  // Interrupt priority encoder
  // ************************************************************
  // Highest active request wins; request 0 means no interrupt
  function automatic logic [2:0] encode_irq(input logic [`IRQ_LEVELS-1:0] req);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 1; i < `IRQ_LEVELS; i++) begin
      if (req[i]) lvl = 3'(i);
    end
    return lvl;
  endfunction : encode_irq
  logic [2:0] next_ipl;
  always_comb begin
    // Top level comes only from the abort key input
    next_ipl = irq_request[7] ? `ABORT_LEVEL : encode_irq({1'b0, irq_request[6:0]});
  end
  always_ff @(posedge clock) begin
    if (rst) irq_level_n <= 3'h7;
    else     irq_level_n <= ~next_ipl;
  end

  // ************************************************************
  // Baud clock from the crystal
  // ************************************************************
  // Counts rising crystal edges, so the rate is unaffected by the processor clock
  logic [11:0] bcnt, next_bcnt;
  logic        xt_prev, next_baud;
  logic [11:0] half_div;
  assign half_div = 12'((`BAUD_DIV_BASE << baud_select) >> 1);
  always_comb begin
    next_bcnt = bcnt;
    next_baud = baud_clock;
    if (xt_lvl && !xt_prev) begin
      if (bcnt >= half_div - 12'h001) begin
        next_bcnt = 12'h000;
        next_baud = ~baud_clock;
      end else begin
        next_bcnt = bcnt + 12'h001;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      bcnt       <= 12'h000;
      xt_prev    <= 1'b0;
      baud_clock <= 1'b0;
    end else begin
      bcnt       <= next_bcnt;
      xt_prev    <= xt_lvl;
      baud_clock <= next_baud;
    end
  end

endmodule : cpu_bus_glue_logic

// ==== testbench/byte_memory_model.sv ====
`timescale 1ns/1ps
// ********
// Byte memory pair
// ********
module byte_memory_model (
  // Clock, reset, bench controls
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        mute,
  input  wire logic [1:0]  wait_lim,
  // Memory side of the glue
  input  wire logic [23:0] byte_addr,
  input  wire logic        upper_write_n,
  input  wire logic        lower_write_n,
  input  wire logic        mem_read_n,
  input  wire logic [7:0]  lane_wdata,
  output logic             mem_ack,
  output logic [7:0]       lane_rdata
);
  logic [7:0] mem [256];
  logic [1:0] wait_cnt;
  // Ready after wait_lim clocks; a muted model stands for an empty address.
  // An idle lane toggles so a stale byte can never pass for read data.
  always @(posedge clock) begin
    if (rst || (mem_read_n && upper_write_n && lower_write_n)) begin
      wait_cnt <= 2'h0;
      mem_ack <= 1'b0;
      lane_rdata <= rst ? 8'hA5 : ~lane_rdata;
    end else begin
      lane_rdata <= mem_read_n ? ~lane_rdata : mem[byte_addr[7:0]];
      wait_cnt <= wait_cnt + {1'b0, wait_cnt != wait_lim};
      mem_ack <= wait_cnt == wait_lim && !mute;
      if (wait_cnt == wait_lim && !mute && mem_read_n)
        mem[byte_addr[7:0]] <= lane_wdata;
    end
  end
endmodule : byte_memory_model

// ==== testbench/cpu_bus_glue_logic_checker.sv ====
`timescale 1ns/1ps
`include "bus_glue_defs.svh"
// ********
// Checker
// ********
module cpu_bus_glue_logic_checker (
  // Inputs
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    address_strobe_line_n,
  input wire logic                    read_write,
  input wire logic                    byte_select_bit,
  input wire logic [`WORD_ADDR_W-1:0] word_addr,
  input wire logic                    periph_select,
  input wire logic                    fault_jumper,
  input wire logic [`IRQ_LEVELS-1:0]  irq_request,
  // Outputs
  input wire logic                    upper_byte_strobe_n,
  input wire logic                    lower_byte_strobe_n,
  input wire logic                    transfer_acknowledge_n,
  input wire logic                    bus_fault_n,
  input wire logic [2:0]              irq_level_n,
  input wire logic                    periph_enable,
  input wire logic [`BYTE_ADDR_W-1:0] byte_addr,
  input wire logic                    upper_write_n,
  input wire logic                    lower_write_n,
  input wire logic                    mem_read_n,
  input wire logic                    valid_peripheral_address_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [9:0] low_cnt;
  logic [9:0] next_low_cnt;
  // Clocks the strobe pin has been low; saturates so a hung cycle never wraps
  always_comb next_low_cnt = address_strobe_line_n ? 10'h000 : low_cnt + {9'h000, ~&low_cnt};
  always_ff @(posedge clock) low_cnt <= rst ? 10'h000 : next_low_cnt;
  function automatic logic [2:0] top_level(input logic [7:0] req);
    top_level = 3'h0;
    for (int i = 1; i < 8; i++)
      if (req[i])
        top_level = 3'(i);
  endfunction : top_level
  sequence enable_high;
    periph_enable [*4];
  endsequence
  sequence enable_low;
    !periph_enable [*6];
  endsequence
  a_upper_only: assert property (
    !upper_byte_strobe_n |-> lower_byte_strobe_n && !byte_addr[0]) else $error("upper strobe");
  a_lower_only: assert property (
    !lower_byte_strobe_n |-> upper_byte_strobe_n && byte_addr[0]) else $error("lower strobe");
  a_lower_gate: assert property (
    !lower_write_n |-> !read_write && !lower_byte_strobe_n && upper_byte_strobe_n)
    else $error("lower write gate");
  a_read_gate: assert property (
    !mem_read_n |-> read_write && upper_write_n && lower_write_n) else $error("read gate");
  a_vma_only: assert property (
    !valid_peripheral_address_n |-> periph_select && transfer_acknowledge_n)
    else $error("adapter window");
  a_addr_form: assert property (
    !upper_byte_strobe_n || !lower_byte_strobe_n |-> byte_addr == {word_addr, byte_select_bit})
    else $error("byte address");
  a_no_periph_ack: assert property (
    periph_select && !address_strobe_line_n |-> transfer_acknowledge_n) else $error("adapter ack");
  a_enable_phases: assert property (
    $rose(periph_enable) |-> enable_high ##1 enable_low) else $error("enable phases");
  a_write_gate: assert property (
    !upper_write_n |-> !read_write && !upper_byte_strobe_n && lower_byte_strobe_n)
    else $error("write gate");
  a_fault_timing: assert property (
    $fell(bus_fault_n) |-> fault_jumper && low_cnt >= 10'h1F0 && low_cnt <= 10'h200)
    else $error("fault timing");
  a_fault_release: assert property (
    address_strobe_line_n [*8] |-> bus_fault_n) else $error("fault held");
  a_irq_encode: assert property (
    !$past(rst) && $stable(irq_request) |-> irq_level_n == ~top_level(irq_request))
    else $error("irq level");
endmodule : cpu_bus_glue_logic_checker

// ==== testbench/cpu_bus_glue_logic_tb_top.sv ====
`timescale 1ns/1ps
`include "bus_glue_defs.svh"
// ********
// Bench
// ********
module cpu_bus_glue_logic_tb_top;
  logic                    clock, rst, address_strobe_line_n, read_write, byte_select_bit;
  logic                    periph_select, mem_ack, fault_jumper, xtal_clock, mute, ack_d;
  logic                    upper_byte_strobe_n, lower_byte_strobe_n, transfer_acknowledge_n;
  logic                    bus_fault_n, valid_peripheral_address_n, periph_enable, baud_clock;
  logic                    upper_write_n, lower_write_n, mem_read_n;
  logic [`WORD_ADDR_W-1:0] word_addr;
  logic [`BYTE_ADDR_W-1:0] byte_addr;
  logic [15:0]             cpu_wdata, cpu_rdata, got, expq [$];
  logic [7:0]              irq_request, lane_rdata, lane_wdata, shadow [256];
  logic [2:0]              baud_select, irq_level_n;
  logic [1:0]              wait_lim;
  int                      num_errors, n_checks, n, e;
  realtime                 t0;
  cpu_bus_glue_logic DUT (.clock, .rst, .address_strobe_line_n, .read_write, .byte_select_bit,
    .word_addr, .cpu_wdata, .periph_select, .mem_ack, .fault_jumper, .baud_select, .irq_request,
    .xtal_clock, .lane_rdata, .cpu_rdata, .upper_byte_strobe_n, .lower_byte_strobe_n,
    .transfer_acknowledge_n, .bus_fault_n, .irq_level_n, .valid_peripheral_address_n,
    .periph_enable, .byte_addr, .upper_write_n, .lower_write_n, .mem_read_n, .lane_wdata,
    .baud_clock);
  byte_memory_model partner (.clock, .rst, .mute, .wait_lim, .byte_addr, .upper_write_n,
    .lower_write_n, .mem_read_n, .lane_wdata, .mem_ack, .lane_rdata);
  // Bus clock and free-running crystal
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    xtal_clock = 1'b0;
    forever #101.725 xtal_clock = ~xtal_clock;
  end
  task automatic check(input logic [15:0] g, x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask : check
  task automatic check_time(input int g, lo, hi);
    n_checks++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("unexpected at %0t: %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask : check_time
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // One processor cycle; ends on acknowledge, fault, adapter window or 700 clocks
  task automatic cycle(input logic rd, input logic [7:0] idx, input logic p, input logic [7:0] d);
    @(posedge clock);
    #2;
    {read_write, byte_select_bit, periph_select} = {rd, idx[0], p};
    word_addr = {16'($urandom), idx[7:1]};
    cpu_wdata = idx[0] ? {~d, d} : {d, ~d};
    if (!p && !mute) begin
      if (!rd)
        shadow[idx] = d;
      expq.push_back({8'h00, shadow[idx]});
    end
    address_strobe_line_n = 1'b0;
    n = 0;
    // Outputs are looked at just after the edge, never in the edge's own time step
    while (n < 700 && transfer_acknowledge_n && bus_fault_n && valid_peripheral_address_n) begin
      @(posedge clock);
      #2;
      n++;
    end
    while (n < 700 && !valid_peripheral_address_n) begin
      @(posedge clock);
      #2;
      n++;
    end
    address_strobe_line_n = 1'b1;
    repeat (10) @(posedge clock);
    #2;
  endtask : cycle
  // Takes the oldest note as each acknowledge begins
  always @(negedge clock) begin
    if (!transfer_acknowledge_n && ack_d && expq.size() > 0) begin
      got = {8'h00, byte_select_bit ? cpu_rdata[7:0] : cpu_rdata[15:8]};
      check(read_write ? got : {8'h00, lane_wdata}, expq.pop_front());
    end
    ack_d = transfer_acknowledge_n;
  end
  initial begin
    {rst, address_strobe_line_n, read_write, byte_select_bit, periph_select} = 5'h1C;
    {fault_jumper, mute, wait_lim, baud_select, irq_request} = 15'h0000;
    {word_addr, cpu_wdata} = 39'h0;
    {num_errors, n_checks, ack_d} = {32'h0, 32'h0, 1'b1};
    void'($urandom(32'hD857));
    repeat (6) @(posedge clock);
    #2 rst = 1'b0;
    // Both halves of four words, then read back: no half may disturb the other
    for (int i = 0; i < 16; i++) begin
      wait_lim = 2'($urandom);
      cycle(i > 7, 8'h30 + 8'(i % 8), 1'b0, 8'($urandom));
    end
    check_time(expq.size(), 0, 0);
    $display("memory test done");
    cycle(1'b1, 8'h51, 1'b1, 8'h00);
    check_time(n, 4, 40);
    $display("adapter test done");
    {mute, fault_jumper} = 2'h3;
    cycle(1'b1, 8'h40, 1'b0, 8'h00);
    check_time(n, 498, 515);
    fault_jumper = 1'b0;
    cycle(1'b0, 8'h41, 1'b0, 8'h00);
    check_time(n, 700, 700);
    mute = 1'b0;
    $display("fault test done");
    for (int l = 0; l < 8; l++) begin
      irq_request = (8'h01 << l) | (8'($urandom) & ((8'h01 << l) - 8'h01));
      repeat (2) @(posedge clock);
      #2 check({13'h0000, irq_level_n}, {13'h0000, ~3'(l)});
    end
    $display("interrupt test done");
    for (int s = 0; s < 4; s += 3) begin
      @(posedge clock);
      #2 baud_select = 3'(s);
      e = (8 << s) * 20345 / 100;
      repeat (3) @(baud_clock);
      t0 = $realtime;
      @(baud_clock);
      check_time(int'($realtime - t0), e - 30, e + 30);
    end
    $display("baud test done");
    summarize();
  end
  // Cuts a hang short long after the expected run
  initial begin
    #1000000;
    num_errors++;
    $display("unexpected at %0t: watchdog", $time);
    summarize();
  end
endmodule : cpu_bus_glue_logic_tb_top
bind cpu_bus_glue_logic cpu_bus_glue_logic_checker chk (.clock, .rst, .address_strobe_line_n,
  .read_write, .byte_select_bit, .word_addr, .periph_select, .fault_jumper, .irq_request,
  .upper_byte_strobe_n, .lower_byte_strobe_n, .transfer_acknowledge_n, .bus_fault_n,
  .irq_level_n, .periph_enable, .byte_addr, .upper_write_n, .lower_write_n, .mem_read_n,
  .valid_peripheral_address_n);
